// ---- hdl/timer16_match_capture.sv ----
`include "timer16_regs.svh"

module timer16_match_capture (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rstn,
  // register port
  input  wire timer16_pkg::reg_req_s regReq,
  output logic [7:0]                 regRdata,
  // capture pin
  input  wire logic                  capture_input_pin,
  // interrupt requests
  output logic                       match_capture_request,
  output logic                       overflow_request
);
  timer16_pkg::timer_state_s s_q;
  timer16_pkg::timer_state_s s_d;
  timer16_pkg::mode_e        mode;
  logic tick;
  logic wrCtl;
  logic riseSeen;
  logic fallSeen;
  logic capEvent;
  logic matchEvent;
  logic ovfEvent;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  timer16_prescaler uPresc (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .divSelect (s_q.divider[3:0]),
    .restart   (wrCtl && regReq.wdata[`CTL_CLEAR]),
    .tick      (tick)
  );

  assign mode  = timer16_pkg::mode_e'(s_q.control[`CTL_MODE_HI:`CTL_MODE_LO]);
  assign wrCtl = regReq.wr && hit(regReq.addr, `CONTROL_OFFSET);

  always_comb begin
    s_d        = s_q;
    // only stages two and three are compared; stage one feeds stage two only
    s_d.capSync = {s_q.capSync[1:0], capture_input_pin};
    riseSeen   = s_q.capSync[1] && !s_q.capSync[2];
    fallSeen   = !s_q.capSync[1] && s_q.capSync[2];
    capEvent   = 1'b0;
    matchEvent = 1'b0;
    ovfEvent   = 1'b0;
    case (mode)
      timer16_pkg::MODE_CAP_RISE: capEvent = riseSeen;
      timer16_pkg::MODE_CAP_FALL: capEvent = fallSeen;
      timer16_pkg::MODE_CAP_BOTH: capEvent = riseSeen || fallSeen;
      default:                    capEvent = 1'b0;
    endcase

    // counter
    if (s_q.control[`CTL_RUN] && tick) begin
      if (mode == timer16_pkg::MODE_INTERVAL &&
          s_q.count == {s_q.refHigh, s_q.refLow}) begin
        matchEvent = 1'b1;
        s_d.count  = 16'h0000;
      end else if (s_q.count == 16'hFFFF) begin
        ovfEvent  = 1'b1;
        s_d.count = 16'h0000;
      end else begin
        s_d.count = s_q.count + 16'h0001;
      end
    end

    // register writes
    if (regReq.wr) begin
      if (hit(regReq.addr, `REF_HIGH_OFFSET)) begin
        s_d.refHigh = regReq.wdata;
      end
      if (hit(regReq.addr, `REF_LOW_OFFSET)) begin
        s_d.refLow = regReq.wdata;
      end
      if (hit(regReq.addr, `DIVIDER_OFFSET)) begin
        s_d.divider = regReq.wdata;
      end
      if (wrCtl) begin
        s_d.control[7:5]          = regReq.wdata[7:5];
        s_d.control[`CTL_OVF_EN]  = regReq.wdata[`CTL_OVF_EN];
        s_d.control[`CTL_MC_EN]   = regReq.wdata[`CTL_MC_EN];
        // pending bits clear on zero; a one written leaves them alone
        if (!regReq.wdata[`CTL_OVF_PEND]) begin
          s_d.control[`CTL_OVF_PEND] = 1'b0;
        end
        if (!regReq.wdata[`CTL_MC_PEND]) begin
          s_d.control[`CTL_MC_PEND] = 1'b0;
        end
        if (regReq.wdata[`CTL_CLEAR]) begin
          s_d.count = 16'h0000;
        end
      end
    end
    // clear bit is self-clearing and never stored
    s_d.control[`CTL_CLEAR] = 1'b0;

    // capture copies the count into the reference pair
    if (capEvent) begin
      s_d.refHigh = s_q.count[15:8];
      s_d.refLow  = s_q.count[7:0];
    end

    // events win over a clear in the same cycle
    if (matchEvent || capEvent) begin
      s_d.control[`CTL_MC_PEND] = 1'b1;
    end
    if (ovfEvent) begin
      s_d.control[`CTL_OVF_PEND] = 1'b1;
    end

    // read data, registered
    if (regReq.rd) begin
      if (hit(regReq.addr, `REF_HIGH_OFFSET)) begin
        s_d.rdata = s_q.refHigh;
      end else if (hit(regReq.addr, `REF_LOW_OFFSET)) begin
        s_d.rdata = s_q.refLow;
      end else if (hit(regReq.addr, `CONTROL_OFFSET)) begin
        s_d.rdata = s_q.control;
      end else if (hit(regReq.addr, `DIVIDER_OFFSET)) begin
        s_d.rdata = s_q.divider;
      end else begin
        s_d.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_q.count   <= 16'h0000;
      s_q.refHigh <= `REF_RESET;
      s_q.refLow  <= `REF_RESET;
      s_q.control <= `CONTROL_RESET;
      s_q.divider <= `DIVIDER_RESET;
      s_q.rdata   <= 8'h00;
      s_q.capSync <= 3'h0;
    end else begin
      s_q <= s_d;
    end
  end

  assign regRdata = s_q.rdata;
  // requests are levels held while pending and enabled
  assign match_capture_request =
    s_q.control[`CTL_MC_PEND] && s_q.control[`CTL_MC_EN];
  assign overflow_request =
    s_q.control[`CTL_OVF_PEND] && s_q.control[`CTL_OVF_EN];
endmodule // timer16_match_capture

// ---- hdl/timer16_regs.svh ----
`ifndef TIMER16_REGS_SVH
`define TIMER16_REGS_SVH
`define REF_HIGH_OFFSET   8'hE0
`define REF_LOW_OFFSET    8'hE1
`define CONTROL_OFFSET    8'hE4
`define DIVIDER_OFFSET    8'hE5
`define REF_RESET         8'hFF
`define CONTROL_RESET     8'h00
`define DIVIDER_RESET     8'h00
`define CTL_MODE_HI       7
`define CTL_MODE_LO       6
`define CTL_RUN           5
`define CTL_CLEAR         4
`define CTL_OVF_EN        3
`define CTL_OVF_PEND      2
`define CTL_MC_EN         1
`define CTL_MC_PEND       0
`define DIVIDER_MAX       4'hC
`endif

// ---- hdl/timer16_pkg.sv ----
package timer16_pkg;
  typedef enum logic [1:0] {
    MODE_INTERVAL,
    MODE_CAP_RISE,
    MODE_CAP_FALL,
    MODE_CAP_BOTH
  } mode_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic [3:0]  cnt;
    logic [11:0] div;
  } presc_state_s;

  typedef struct packed {
    logic [15:0] count;
    logic [7:0]  refHigh;
    logic [7:0]  refLow;
    logic [7:0]  control;
    logic [7:0]  divider;
    logic [7:0]  rdata;
    logic [2:0]  capSync;
  } timer_state_s;
endpackage

// ---- hdl/timer16_prescaler.sv ----
`include "timer16_regs.svh"

// divides ref_clk by 2**n, n above 12 taken as 12, into a one-cycle tick
module timer16_prescaler (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // control
  input  wire logic [3:0] divSelect,
  input  wire logic       restart,
  // tick out
  output logic            tick
);
  timer16_pkg::presc_state_s s_q;
  timer16_pkg::presc_state_s s_d;
  logic [11:0] limit;

  always_comb begin
    s_d   = s_q;
    limit = 12'h000;
    // values above twelve are invalid; clamp so the divider stays bounded
    if (divSelect > `DIVIDER_MAX) begin
      limit = 12'hFFF;
    end else begin
      limit = 12'(13'h0001 << divSelect) - 12'h001;
    end
    tick = (s_q.div >= limit);
    // a new divide ratio starts a fresh period instead of finishing the old one
    if (restart || tick || (s_q.cnt != divSelect)) begin
      s_d.div = 12'h000;
    end else begin
      s_d.div = s_q.div + 12'h001;
    end
    s_d.cnt = divSelect;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // timer16_prescaler

// ---- tb/timer16_match_capture_chk.sv ----
module timer16_match_capture_chk (
  // clock and reset
  input wire logic                  ref_clk,
  input wire logic                  rstn,
  // register port
  input wire timer16_pkg::reg_req_s regReq,
  input wire logic [7:0]            regRdata,
  // pin and requests
  input wire logic                  capture_input_pin,
  input wire logic                  match_capture_request,
  input wire logic                  overflow_request
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic ctlWr;
  assign ctlWr = regReq.wr && regReq.addr == 8'hE4;
  property p_rst_quiet;
    $rose(rstn) |-> !match_capture_request && !overflow_request;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("request after reset");
  property p_mc_off;
    ctlWr && !regReq.wdata[1] |=> !match_capture_request;
  endproperty
  a_mc_off: assert property (p_mc_off) else $error("match request not off");
  property p_ovf_off;
    ctlWr && !regReq.wdata[3] |=> !overflow_request;
  endproperty
  a_ovf_off: assert property (p_ovf_off) else $error("ovf request not off");
  property p_mc_keep;
    match_capture_request && ctlWr && regReq.wdata[1:0] == 2'h3
      |=> match_capture_request;
  endproperty
  a_mc_keep: assert property (p_mc_keep) else $error("one cleared pending");
  property p_ovf_keep;
    overflow_request && ctlWr && regReq.wdata[3:2] == 2'h3
      |=> overflow_request;
  endproperty
  a_ovf_keep: assert property (p_ovf_keep) else $error("one cleared ovf");
  property p_clr_rd;
    regReq.rd && regReq.addr == 8'hE4 |=> !regRdata[4];
  endproperty
  a_clr_rd: assert property (p_clr_rd) else $error("clear bit read one");
  property p_unmapped;
    regReq.rd && !(regReq.addr inside {8'hE0, 8'hE1, 8'hE4, 8'hE5})
      |=> regRdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
  property p_rd_hold;
    !regReq.rd |=> $stable(regRdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule // timer16_match_capture_chk

// ---- tb/timer16_pin_model.sv ----
// external source on the capture pin; changes are asynchronous to ref_clk
module timer16_pin_model (
  // pin
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pin = 1'b0;
  task drive(input logic v);
    #7 pin = v;
  endtask
endmodule // timer16_pin_model

// ---- tb/tb_timer16_match_capture.sv ----
module tb_timer16_match_capture;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rstn, capPin, mcReq, ovfReq;
  logic [7:0] rdata;
  timer16_pkg::reg_req_s req;
  int n_mismatch = 0;
  int check_count = 0;
  timer16_match_capture u_timer16_match_capture (.ref_clk(ref_clk),
    .rstn(rstn), .regReq(req), .regRdata(rdata),
    .capture_input_pin(capPin), .match_capture_request(mcReq),
    .overflow_request(ovfReq));
  timer16_pin_model u_timer16_pin_model (.pin(capPin));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task chk(input logic [7:0] act, input logic [7:0] exp);
    check_count++;
    if (act !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, act, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) req <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk) req <= '0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk) req <= '0;
    #1 chk(rdata, exp);
  endtask
  task wait_req(input bit ovf, input int lim, input logic exp);
    for (int i = 0; i < lim && !(ovf ? ovfReq : mcReq); i++) @(posedge ref_clk);
    #1 chk({7'h0, ovf ? ovfReq : mcReq}, {7'h0, exp});
  endtask
  task t_reset;
    rd(8'hE0, 8'hFF);
    rd(8'hE1, 8'hFF);
    rd(8'hE4, 8'h00);
    rd(8'hE5, 8'h00);
    rd(8'hE2, 8'h00);
    wr(8'hE0, 8'h12);
    rd(8'hE0, 8'h12);
    wr(8'hE5, 8'h0C);
    rd(8'hE5, 8'h0C);
    wr(8'hE5, 8'h00);
  endtask
  task t_match;
    wr(8'hE0, 8'h00);
    wr(8'hE1, 8'h05);
    wr(8'hE4, 8'h30);
    repeat (20) @(posedge ref_clk);
    wait_req(1'b0, 1, 1'b0);
    rd(8'hE4, 8'h21);
    wr(8'hE4, 8'h23);
    wait_req(1'b0, 4, 1'b1);
    wr(8'hE4, 8'h03);
    rd(8'hE4, 8'h03);
    wr(8'hE4, 8'h02);
    rd(8'hE4, 8'h02);
  endtask
  task t_ovf;
    // capture mode keeps the match compare from swallowing the wrap
    wr(8'hE4, 8'h78);
    wait_req(1'b1, 70000, 1'b1);
    wr(8'hE4, 8'h4C);
    rd(8'hE4, 8'h4C);
    wr(8'hE4, 8'h48);
    rd(8'hE4, 8'h48);
  endtask
  task t_cap;
    for (int m = 1; m < 4; m++) begin
      wr(8'hE0, 8'hAA);
      wr(8'hE4, {m[1:0], 6'h32});
      u_timer16_pin_model.drive(1'b1);
      repeat (6) @(posedge ref_clk);
      wait_req(1'b0, 1, m != 2);
      if (m != 2) rd(8'hE0, 8'h00);
      wr(8'hE4, {m[1:0], 6'h22});
      u_timer16_pin_model.drive(1'b0);
      repeat (6) @(posedge ref_clk);
      wait_req(1'b0, 1, m != 1);
    end
  endtask
  task t_div;
    int n;
    wr(8'hE5, 8'h02);
    wr(8'hE1, 8'h03);
    wr(8'hE0, 8'h00);
    wr(8'hE4, 8'h32);
    n = 0;
    #1;
    while (!mcReq && n < 40) begin
      @(posedge ref_clk) #1 n++;
    end
    chk(n[7:0], 8'h10);
    wr(8'hE4, 8'h02);
    repeat (40) @(posedge ref_clk);
    wait_req(1'b0, 1, 1'b0);
    wr(8'hE5, 8'h00);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    req = '0;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset;
    t_match;
    t_ovf;
    t_cap;
    t_div;
    wrap_up;
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    n_mismatch++;
    wrap_up;
  end
endmodule // tb_timer16_match_capture
bind timer16_match_capture timer16_match_capture_chk u_chk (.ref_clk(ref_clk),
  .rstn(rstn), .regReq(regReq), .regRdata(regRdata),
  .capture_input_pin(capture_input_pin),
  .match_capture_request(match_capture_request),
  .overflow_request(overflow_request));
